//--- verilog/multi_port_pin_io_regs.svh
// register map, reset values and field widths of the four pin ports
// assumes an APB slave with word-aligned registers, byte address = index * 4
// Summary of operation
// [R01] software writes latch bit one before using a first high-current pin as input
// [R02] first high-current port latch resets to all ones
// [R03] first high-current port: latch at one address, live pins at another
// [R04] software keeps serial-port latch bit one for input or serial use
// [R05] serial-port latch resets to ones, drive-type register to zeros
// [R06] drive-type zero gives sink-only open drain, one gives push-pull
// [R07] for serial-port input, software sets latch one, then drive-type zero
// [R08] serial port: latch at one address, live pins at a read-only address
// [R09] second high-current port has five bits, latch and pin readback apart
// [R10] second high-current latch resets to ones; software keeps one for input
// [R11] bits 7 to 5 of the five-bit port read as undefined; the code reads them as zero
// [R12] analog port resets direction to input, input enable to ones, latch zero
// [R13] analog direction bit one drives the latch value onto the pin
// [R14] for digital input, software clears direction then sets input enable
// [R15] for key-on wakeup, software clears direction then sets wakeup select
// [R16] for analog input, software clears direction then clears input enable
// [R17] analog data read: latch if output, pin if enabled input, else zero
// [R18] open-drain serial pin with latch one stays undriven
`ifndef MULTI_PORT_PIN_IO_REGS_SVH
`define MULTI_PORT_PIN_IO_REGS_SVH

// register indices; byte address is the index times four
`define HC_A_LATCH_IDX       12'h003
`define SERIAL_LATCH_IDX     12'h004
`define HC_B_LATCH_IDX       12'h005
`define ANALOG_DATA_IDX      12'h006
`define SERIAL_DRIVE_IDX     12'h00A
`define HC_A_PIN_IDX         12'h00D
`define SERIAL_PIN_IDX       12'h00E
`define HC_B_PIN_IDX         12'h00F
`define WAKEUP_SEL_IDX       12'h010
`define ANALOG_DIR_IDX       12'hF9B
`define ANALOG_IEN_IDX       12'hF9C

// reset values
`define HC_A_LATCH_RST       8'hFF
`define SERIAL_LATCH_RST     8'hFF
`define SERIAL_DRIVE_RST     8'h00
`define HC_B_LATCH_RST       5'h1F
`define ANALOG_DATA_RST      8'h00
`define ANALOG_DIR_RST       8'h00
`define ANALOG_IEN_RST       8'hFF
`define WAKEUP_SEL_RST       4'h0

// field widths
`define HC_B_WIDTH           5
`define WAKEUP_WIDTH         4

`endif

//--- verilog/multi_port_pin_io_pkg.sv
// types shared by the pin port block
// assumes the constants header supplies widths and reset values
package multi_port_pin_io_pkg;

    typedef logic [7:0] port_byte_t;
    typedef logic [4:0] hc_b_bits_t;
    typedef logic [3:0] wake_bits_t;

    // read answer phase of the bus slave
    typedef enum logic [0:0] {
        ANS_WAIT  = 1'b0,
        ANS_READY = 1'b1
    } answer_state_t;

endpackage

//--- verilog/multi_port_pin_io.sv
// four general-purpose pin ports behind an APB slave
// assumes pin inputs synchronous to pclk; pads resolve level from out and oe
`timescale 1ns/1ns
`include "multi_port_pin_io_regs.svh"

module multi_port_pin_io (
    // clock, reset, enable
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            ce,
    // apb slave
    input  wire logic                            psel,
    input  wire logic                            penable,
    input  wire logic                            pwrite,
    input  wire logic [15:0]                     paddr,
    input  wire logic [31:0]                     pwdata,
    input  wire logic [3:0]                      pstrb,
    output logic      [31:0]                     prdata,
    output logic                                 pready,
    output logic                                 pslverr,
    // first high-current port
    input  wire logic [7:0]                      hc_a_in,
    output logic      [7:0]                      hc_a_out,
    output logic      [7:0]                      hc_a_oe,
    // serial-shared port
    input  wire logic [7:0]                      serial_in,
    output logic      [7:0]                      serial_out,
    output logic      [7:0]                      serial_oe,
    // second high-current port
    input  wire logic [4:0]                      hc_b_in,
    output logic      [4:0]                      hc_b_out,
    output logic      [4:0]                      hc_b_oe,
    // analog-shared port
    input  wire logic [7:0]                      analog_in,
    output logic      [7:0]                      analog_out,
    output logic      [7:0]                      analog_oe,
    // controls for the analog and wakeup logic outside
    output logic      [7:0]                      analog_input_enable,
    output logic      [3:0]                      wakeup_input_select
);

    // register state
    multi_port_pin_io_pkg::port_byte_t    hc_a_latch_q;
    multi_port_pin_io_pkg::port_byte_t    serial_latch_q;
    multi_port_pin_io_pkg::port_byte_t    serial_drive_q;
    multi_port_pin_io_pkg::hc_b_bits_t    hc_b_latch_q;
    multi_port_pin_io_pkg::port_byte_t    analog_data_q;
    multi_port_pin_io_pkg::port_byte_t    analog_dir_q;
    multi_port_pin_io_pkg::port_byte_t    analog_ien_q;
    multi_port_pin_io_pkg::wake_bits_t    wakeup_sel_q;

    // bus answer state
    multi_port_pin_io_pkg::answer_state_t ans_q;
    multi_port_pin_io_pkg::answer_state_t ans_d;
    logic [31:0]                          rdata_q;
    logic                                 rerr_q;

    // true when the bus address names register idx
    function automatic logic reg_hit(input logic [15:0] addr,
                                     input logic [11:0] idx);
        reg_hit = (addr[1:0] == 2'h0) && (addr[15:14] == 2'h0)
                  && (addr[13:2] == idx);
    endfunction

    // one register's share of the read byte, zero unless selected
    function automatic logic [7:0] rd_gate(input logic       hit,
                                           input logic [7:0] value);
        rd_gate = {8{hit}} & value;
    endfunction

    // address decode
    wire sel_hc_a_latch   = reg_hit(paddr, `HC_A_LATCH_IDX);
    wire sel_serial_latch = reg_hit(paddr, `SERIAL_LATCH_IDX);
    wire sel_hc_b_latch   = reg_hit(paddr, `HC_B_LATCH_IDX);
    wire sel_analog_data  = reg_hit(paddr, `ANALOG_DATA_IDX);
    wire sel_serial_drive = reg_hit(paddr, `SERIAL_DRIVE_IDX);
    wire sel_hc_a_pin     = reg_hit(paddr, `HC_A_PIN_IDX);
    wire sel_serial_pin   = reg_hit(paddr, `SERIAL_PIN_IDX);
    wire sel_hc_b_pin     = reg_hit(paddr, `HC_B_PIN_IDX);
    wire sel_wakeup       = reg_hit(paddr, `WAKEUP_SEL_IDX);
    wire sel_analog_dir   = reg_hit(paddr, `ANALOG_DIR_IDX);
    wire sel_analog_ien   = reg_hit(paddr, `ANALOG_IEN_IDX);

    wire sel_writable = sel_hc_a_latch | sel_serial_latch | sel_hc_b_latch
                      | sel_analog_data | sel_serial_drive | sel_wakeup
                      | sel_analog_dir | sel_analog_ien;
    wire sel_readonly = sel_hc_a_pin | sel_serial_pin | sel_hc_b_pin;
    wire sel_any      = sel_writable | sel_readonly;

    // a write to a pin-readback address is refused like an unmapped one
    wire bad_access   = ~sel_any | (pwrite & sel_readonly);

    // writes land only on the completing edge, lane 0 carries the byte
    wire complete     = psel & penable & pready;
    wire wr_en        = complete & pwrite & pstrb[0] & ~bad_access;
    wire [7:0] wbyte  = pwdata[7:0];

    wire wr_hc_a_latch   = wr_en & sel_hc_a_latch;
    wire wr_serial_latch = wr_en & sel_serial_latch;
    wire wr_hc_b_latch   = wr_en & sel_hc_b_latch;
    wire wr_analog_data  = wr_en & sel_analog_data;
    wire wr_serial_drive = wr_en & sel_serial_drive;
    wire wr_wakeup       = wr_en & sel_wakeup;
    wire wr_analog_dir   = wr_en & sel_analog_dir;
    wire wr_analog_ien   = wr_en & sel_analog_ien;

    // analog data read view, per bit
    wire [7:0] analog_view = (analog_dir_q & analog_data_q)                  // [R17]
                           | (~analog_dir_q & analog_ien_q & analog_in);     // [R17]

    // upper three bits of the five-bit port read as zero
    wire [7:0] hc_b_latch_view = {3'h0, hc_b_latch_q};                       // [R11]
    wire [7:0] hc_b_pin_view   = {3'h0, hc_b_in};                            // [R11]

    // read multiplexer
    wire [7:0] rd_byte =
          rd_gate(sel_hc_a_latch,   hc_a_latch_q)                            // [R03]
        | rd_gate(sel_hc_a_pin,     hc_a_in)                                 // [R03]
        | rd_gate(sel_serial_latch, serial_latch_q)                          // [R08]
        | rd_gate(sel_serial_pin,   serial_in)                               // [R08]
        | rd_gate(sel_serial_drive, serial_drive_q)
        | rd_gate(sel_hc_b_latch,   hc_b_latch_view)                         // [R09]
        | rd_gate(sel_hc_b_pin,     hc_b_pin_view)                           // [R09]
        | rd_gate(sel_analog_data,  analog_view)                             // [R17]
        | rd_gate(sel_analog_dir,   analog_dir_q)
        | rd_gate(sel_analog_ien,   analog_ien_q)
        | rd_gate(sel_wakeup,       {4'h0, wakeup_sel_q});

    // answer sequencing: sample read data while psel is up, answer once
    // a sample has been taken with the clock enabled
    always_comb begin
        ans_d = ans_q;
        unique case (ans_q)
            multi_port_pin_io_pkg::ANS_WAIT: begin
                if (psel) begin
                    ans_d = multi_port_pin_io_pkg::ANS_READY;
                end
            end
            multi_port_pin_io_pkg::ANS_READY: begin
                // a dropped select abandons the answer rather than hold it
                if (complete || !psel) begin
                    ans_d = multi_port_pin_io_pkg::ANS_WAIT;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ans_q <= multi_port_pin_io_pkg::ANS_WAIT;
        end else if (ce) begin
            ans_q <= ans_d;
        end
    end

    // read data comes from flops so the bus sees a stable word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
            rerr_q  <= 1'b0;
        end else if (ce && psel && !complete) begin
            rdata_q <= (pwrite || bad_access) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
            rerr_q  <= bad_access;
        end
    end

    // a frozen clock enable stalls the bus rather than losing a transfer
    assign pready  = ce & (ans_q == multi_port_pin_io_pkg::ANS_READY);
    assign prdata  = rdata_q;
    assign pslverr = pready & psel & penable & rerr_q;

    // first high-current port latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hc_a_latch_q <= `HC_A_LATCH_RST;                                 // [R02]
        end else if (ce && wr_hc_a_latch) begin
            hc_a_latch_q <= wbyte;
        end
    end

    // serial-shared port latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_latch_q <= `SERIAL_LATCH_RST;                             // [R05]
        end else if (ce && wr_serial_latch) begin
            serial_latch_q <= wbyte;
        end
    end

    // serial-shared port drive type
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_drive_q <= `SERIAL_DRIVE_RST;                             // [R05]
        end else if (ce && wr_serial_drive) begin
            serial_drive_q <= wbyte;
        end
    end

    // second high-current port latch, five bits only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hc_b_latch_q <= `HC_B_LATCH_RST;                                 // [R10]
        end else if (ce && wr_hc_b_latch) begin
            hc_b_latch_q <= wbyte[`HC_B_WIDTH-1:0];                          // [R09]
        end
    end

    // analog-shared port latch; a write lands even in input mode, so
    // read-modify-write on mixed-direction pins can change input latches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_data_q <= `ANALOG_DATA_RST;                               // [R12]
        end else if (ce && wr_analog_data) begin
            analog_data_q <= wbyte;
        end
    end

    // analog-shared port direction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_dir_q <= `ANALOG_DIR_RST;                                 // [R12]
        end else if (ce && wr_analog_dir) begin
            analog_dir_q <= wbyte;
        end
    end

    // analog-shared port digital input enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_ien_q <= `ANALOG_IEN_RST;                                 // [R12]
        end else if (ce && wr_analog_ien) begin
            analog_ien_q <= wbyte;
        end
    end

    // key-on wakeup select, one bit per upper analog pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wakeup_sel_q <= `WAKEUP_SEL_RST;
        end else if (ce && wr_wakeup) begin
            wakeup_sel_q <= wbyte[`WAKEUP_WIDTH-1:0];
        end
    end

    // high-current ports sink only: a latch one releases the pin,
    // which is why an input pin needs its latch at one
    assign hc_a_out = 8'h00;
    assign hc_a_oe  = ~hc_a_latch_q;                                         // [R01]
    assign hc_b_out = 5'h00;
    assign hc_b_oe  = ~hc_b_latch_q;                                         // [R10]

    // serial port: push-pull drives always, open drain only pulls low
    assign serial_out = serial_latch_q;                                      // [R06]
    assign serial_oe  = serial_drive_q | ~serial_latch_q;                    // [R18]

    // analog port drives the latch only in output mode
    assign analog_out = analog_data_q;                                       // [R13]
    assign analog_oe  = analog_dir_q;                                        // [R13]

    // controls handed to the converter and wakeup logic
    assign analog_input_enable = analog_ien_q;
    assign wakeup_input_select = wakeup_sel_q;

endmodule

//--- tb/multi_port_pin_io_chk.sv
// assertions on bus writes and pad controls of the pin ports
// assumes binding onto multi_port_pin_io, byte address = index * 4
`timescale 1ns/1ns
`include "multi_port_pin_io_regs.svh"
module multi_port_pin_io_chk (
    // clock, reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    // pads
    input wire logic [7:0]  hc_a_oe,
    input wire logic [7:0]  serial_out,
    input wire logic [7:0]  serial_oe,
    input wire logic [4:0]  hc_b_oe,
    input wire logic [7:0]  analog_out,
    input wire logic [7:0]  analog_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_acc(logic [11:0] i);
        psel && penable && pready && pwrite && paddr == {2'b00, i, 2'b00};
    endsequence
    // strobe off means no write, so only strobed accesses count
    sequence s_wr(logic [11:0] i);
        s_acc(i) ##0 pstrb[0];
    endsequence
    a_reset_pads: assert property (
        $rose(presetn) |-> hc_a_oe == 8'h00 && hc_b_oe == 5'h00 && serial_out == 8'hFF
        && serial_oe == 8'h00 && analog_oe == 8'h00 && analog_out == 8'h00)
        else $error("pads wrong after reset");
    a_hc_a_sink: assert property (
        s_wr(`HC_A_LATCH_IDX) |=> hc_a_oe == ~$past(pwdata[7:0])) else $error("hc_a pads");
    a_serial_latch: assert property (
        s_wr(`SERIAL_LATCH_IDX) |=> serial_out == $past(pwdata[7:0])) else $error("serial out");
    a_drive_kind: assert property (
        s_wr(`SERIAL_DRIVE_IDX) |=> serial_oe == ($past(pwdata[7:0]) | ~serial_out))
        else $error("serial enable");
    a_hc_b_sink: assert property (
        s_wr(`HC_B_LATCH_IDX) |=> hc_b_oe == ~$past(pwdata[4:0])) else $error("hc_b pads");
    a_analog_dir: assert property (
        s_wr(`ANALOG_DIR_IDX) |=> analog_oe == $past(pwdata[7:0])) else $error("analog dir");
    a_analog_latch: assert property (
        s_wr(`ANALOG_DATA_IDX) |=> analog_out == $past(pwdata[7:0])) else $error("analog out");
    a_pin_readonly: assert property (
        (s_acc(`HC_A_PIN_IDX) or s_acc(`SERIAL_PIN_IDX)) |-> pslverr) else $error("ro write ok");
endmodule

bind multi_port_pin_io multi_port_pin_io_chk u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .hc_a_oe(hc_a_oe),
    .serial_out(serial_out), .serial_oe(serial_oe), .hc_b_oe(hc_b_oe),
    .analog_out(analog_out), .analog_oe(analog_oe));

//--- tb/board_pins.sv
// board side of the four ports: one external level per pin
// assumes an enabled pad wins over the board, else the board level shows
`timescale 1ns/1ns
module board_pins (
    // pad controls
    input wire logic [7:0] hc_a_out,
    input wire logic [7:0] hc_a_oe,
    input wire logic [7:0] serial_out,
    input wire logic [7:0] serial_oe,
    input wire logic [4:0] hc_b_out,
    input wire logic [4:0] hc_b_oe,
    input wire logic [7:0] analog_out,
    input wire logic [7:0] analog_oe,
    // board levels, seen on the pin where the pad is undriven
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_s,
    input wire logic [4:0] ext_b,
    input wire logic [7:0] ext_n,
    // resolved pins
    output logic     [7:0] hc_a_in,
    output logic     [7:0] serial_in,
    output logic     [4:0] hc_b_in,
    output logic     [7:0] analog_in
);
    assign hc_a_in   = (hc_a_oe & hc_a_out) | (~hc_a_oe & ext_a);
    assign serial_in = (serial_oe & serial_out) | (~serial_oe & ext_s);
    assign hc_b_in   = (hc_b_oe & hc_b_out) | (~hc_b_oe & ext_b);
    assign analog_in = (analog_oe & analog_out) | (~analog_oe & ext_n);
endmodule

//--- tb/testbench.sv
// self-checking bench of the pin ports over apb
// assumes board_pins on the pads and the checker bound in its own file
`timescale 1ns/1ns
`include "multi_port_pin_io_regs.svh"
module testbench;
    logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, erv;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [3:0]  pstrb, wakeup_input_select;
    logic [7:0]  hc_a_in, hc_a_out, hc_a_oe, serial_in, serial_out, serial_oe, exp8;
    logic [7:0]  analog_in, analog_out, analog_oe, analog_input_enable, ext_a, ext_s, ext_n;
    logic [4:0]  hc_b_in, hc_b_out, hc_b_oe, ext_b;
    int          err_count = 0, checked = 0, cyc = 0;
    multi_port_pin_io DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .hc_a_in(hc_a_in),
        .hc_a_out(hc_a_out), .hc_a_oe(hc_a_oe), .serial_in(serial_in), .serial_out(serial_out),
        .serial_oe(serial_oe), .hc_b_in(hc_b_in), .hc_b_out(hc_b_out), .hc_b_oe(hc_b_oe),
        .analog_in(analog_in), .analog_out(analog_out), .analog_oe(analog_oe),
        .analog_input_enable(analog_input_enable), .wakeup_input_select(wakeup_input_select));
    board_pins u_board (.hc_a_out(hc_a_out), .hc_a_oe(hc_a_oe), .serial_out(serial_out),
        .serial_oe(serial_oe), .hc_b_out(hc_b_out), .hc_b_oe(hc_b_oe), .analog_out(analog_out),
        .analog_oe(analog_oe), .ext_a(ext_a), .ext_s(ext_s), .ext_b(ext_b), .ext_n(ext_n),
        .hc_a_in(hc_a_in), .serial_in(serial_in), .hc_b_in(hc_b_in), .analog_in(analog_in));
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic test_done;
        if (err_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard, far above the 150 or so cycles used
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            test_done;
        end
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        checked = checked + 1;
        if (s !== x) begin
            err_count = err_count + 1;
            $display("BAD %s exp %h saw %h", nm, x, s);
        end
    endtask
    // pready read at the rising edge, before that edge's flop updates land
    task automatic xfer(input logic w, input logic [11:0] i, input logic [7:0] d, input logic s);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b00, i, 2'b00};
        pwdata <= {24'h000000, d}; pstrb <= {3'b000, s};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] i, input logic [7:0] d);
        xfer(1'b1, i, d, 1'b1);
    endtask
    task automatic rd(input string nm, input logic [11:0] i, input logic [7:0] x);
        xfer(1'b0, i, 8'h00, 1'b1);
        chk(nm, rdv, {24'h000000, x});
    endtask
    initial begin
        presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
        pwdata = 32'h00000000; pstrb = 4'h0; ext_a = 8'hF0; ext_s = 8'h99; ext_b = 5'h0A;
        ext_n = 8'h3C;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd("hca_latch", `HC_A_LATCH_IDX, 8'hFF);
        rd("ser_latch", `SERIAL_LATCH_IDX, 8'hFF);
        rd("ser_drive", `SERIAL_DRIVE_IDX, 8'h00);
        rd("hcb_latch", `HC_B_LATCH_IDX, 8'h1F);
        rd("an_ien", `ANALOG_IEN_IDX, 8'hFF);
        rd("an_dir", `ANALOG_DIR_IDX, 8'h00);
        rd("hca_pin", `HC_A_PIN_IDX, 8'hF0);
        wr(`HC_A_LATCH_IDX, 8'h5A);
        rd("hca_latch", `HC_A_LATCH_IDX, 8'h5A);
        rd("hca_pin", `HC_A_PIN_IDX, 8'h50);
        wr(`SERIAL_LATCH_IDX, 8'h3C);
        wr(`SERIAL_DRIVE_IDX, 8'h0F);
        rd("ser_pin", `SERIAL_PIN_IDX, 8'h1C);
        wr(`SERIAL_LATCH_IDX, 8'hFF);
        wr(`SERIAL_DRIVE_IDX, 8'h00);
        rd("ser_pin", `SERIAL_PIN_IDX, 8'h99);
        wr(`HC_B_LATCH_IDX, 8'hFE);
        rd("hcb_latch", `HC_B_LATCH_IDX, 8'h1E);
        rd("hcb_pin", `HC_B_PIN_IDX, 8'h0A);
        xfer(1'b1, `HC_A_PIN_IDX, 8'h00, 1'b1);
        chk("ro_err", {31'h0, erv}, 32'h1);
        xfer(1'b1, 12'h0FF, 8'h00, 1'b1);
        chk("map_err", {31'h0, erv}, 32'h1);
        xfer(1'b1, `HC_A_LATCH_IDX, 8'h00, 1'b0);
        rd("hca_strb", `HC_A_LATCH_IDX, 8'h5A);
        // clock enable low: the write must stall, not land or vanish
        ce <= 1'b0;
        fork
            wr(`HC_A_LATCH_IDX, 8'h33);
            begin
                repeat (6) @(posedge pclk);
                chk("ce_hold", {24'h0, hc_a_oe}, 32'hA5);
                ce <= 1'b1;
            end
        join
        rd("hca_ce", `HC_A_LATCH_IDX, 8'h33);
        wr(`ANALOG_DIR_IDX, 8'hFF);
        rd("an_rst", `ANALOG_DATA_IDX, 8'h00);
        wr(`ANALOG_DATA_IDX, 8'hA5);
        for (int k = 0; k < 4; k++) begin
            wr(`ANALOG_DIR_IDX, k[1] ? 8'hFF : 8'h00);
            wr(`ANALOG_IEN_IDX, k[0] ? 8'hFF : 8'h00);
            exp8 = k[1] ? 8'hA5 : (k[0] ? 8'h3C : 8'h00);
            rd("an_data", `ANALOG_DATA_IDX, exp8);
            chk("an_ien_out", {24'h0, analog_input_enable}, k[0] ? 32'hFF : 32'h0);
        end
        wr(`ANALOG_DIR_IDX, 8'h00);
        wr(`WAKEUP_SEL_IDX, 8'h0B);
        // the write lands at the completing edge; look one edge later
        @(posedge pclk);
        chk("wake", {28'h0, wakeup_input_select}, 32'hB);
        // second reset in mid-run must restore the reset values
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd("hca_rst2", `HC_A_LATCH_IDX, 8'hFF);
        rd("an_dir_rst2", `ANALOG_DIR_IDX, 8'h00);
        test_done;
    end
endmodule
